/* src/idm_ctrl.sv */
// interrupt/dma mode control register with request routing and pin drive
// assumes a classic wishbone master, one 50 MHz clock, converter events
// on the same clock, and host dma pins that need synchronising
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps

// Overview of operation
// - write-only 16-bit control word at offset 04, cleared by reset.
// - bit 15 enables the serial sample link to the processing board.
// - bit 14 lets the output latch drive the upper digital port.
// - bit 13 lets the output latch drive lower digital lines one to four.
// - bit 12 raises an interrupt on terminal count; clear strobe ends it.
// - bit 11 raises an interrupt at output sequence end; strobe clears it.
// - bit 10 raises an interrupt at acquisition end; strobe clears it.
// - bit 9 with channel and request bits selects input/output interrupts.
// - bit 8 enables requests on the primary dma channel only.
// - bit 7 enables requests on the secondary dma channel only.
// - bit 6 makes a result in the input fifo issue a request.
// - primary channel alone feeds converter 0, 1, both, or carries samples.
// - secondary channel alone maps the same way as the primary.
// - both channels serve converters double-buffered, or synchronously for pattern 011.
// - both channels with conversion request alone alternate input samples double-buffered.
// - bits 5 and 4 request when converter 1 or 0 is ready.
// - interrupts without dma give timer and conversion interrupts, possibly together.
// - bits 2 to 0 pick host interrupt level 3,4,5,7,10,11,12,15.
// - bit 3 grounds the sense pin except in non-referenced single-ended mode.
module idm_ctrl import idm_pkg::*; (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [WB_AW-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [WB_DW-1:0] WB_DAT_I,
  output logic [WB_DW-1:0] WB_DAT_O,
  output logic WB_ACK_O,
  // host dma controller pins
  input wire logic TRANSFER_TERMINAL_COUNT,
  input wire logic DMA_ACK_A_N,
  input wire logic DMA_ACK_B_N,
  output logic DMA_REQ_A,
  output logic DMA_REQ_B,
  // host interrupt lines, one per level
  output logic [NUM_LEVELS-1:0] IRQ_LEVEL_O,
  // converter events on this clock
  input wire logic CONV_AVAIL,
  input wire logic OUT0_READY,
  input wire logic OUT1_READY,
  input wire logic OUT_SEQ_DONE,
  input wire logic ACQ_SEQ_DONE,
  // serial sample link
  output logic SAMPLE_LINK_ENABLE,
  // digital port lines
  input wire logic [DIG_W-1:0] DIG_OUT_LATCH,
  input wire logic [DIG_W-1:0] DIGITAL_PORT_LINE_I,
  output logic [DIG_W-1:0] DIGITAL_PORT_LINE_O,
  output logic [DIG_W-1:0] DIGITAL_PORT_LINE_OE,
  // analog sense pin
  input wire logic NONREFERENCED_SINGLE_ENDED,
  output logic ANALOG_SENSE_PIN_O,
  output logic ANALOG_SENSE_PIN_OE
);

  // control word and its fields
  logic [CTRL_W-1:0] ctrl;
  wire sample_link_enable = ctrl[B_LINK];
  wire upper_port_drive_enable = ctrl[B_UP_EN];
  wire lower_port_drive_enable = ctrl[B_LO_EN];
  wire transfer_count_irq_enable = ctrl[B_TC_IE];
  wire output_done_irq_enable = ctrl[B_OD_IE];
  wire acquisition_done_irq_enable = ctrl[B_AD_IE];
  wire primary_channel_enable = ctrl[B_CHA];
  wire secondary_channel_enable = ctrl[B_CHB];
  wire conversion_request_enable = ctrl[B_CONV];
  wire output1_request_enable = ctrl[B_OUT1];
  wire output0_request_enable = ctrl[B_OUT0];
  wire sense_ground_drive = ctrl[B_SENSE];
  wire [2:0] irq_line_select = ctrl[B_LSEL_HI:B_LSEL_LO];

  // bus handshake state
  logic ack;
  logic [WB_DW-1:0] rd_data;

  // synchronised pins and their previous values
  logic [SYNC_W-1:0] pin_s;
  logic [2:0] pin_prev;

  // sticky completion flags
  logic tc_pend;
  logic out_pend;
  logic acq_pend;

  // dma channel sequencing state
  idm_buf_e buf_sel;
  idm_buf_e next_buf_sel;
  logic phase_a;
  logic phase_b;
  logic irq_any;

  // mode decode link
  // the decoder holds no state
  idm_mode_if mode ();

  // ready test of a channel source; interleaving alternates converters
  // source none is never ready
  function automatic logic src_ready(input idm_src_e s, input logic ph,
                                     input logic conv, input logic r0, input logic r1);
    case (s)
      SRC_CONV: src_ready = conv;
      SRC_OUT0: src_ready = r0;
      SRC_OUT1: src_ready = r1;
      SRC_OUTI: src_ready = ph ? r1 : r0;
      default: src_ready = 1'b0;
    endcase
  endfunction : src_ready

  // mode decoder fed from the control word
  assign mode.io_int = ctrl[B_IO_INT];
  assign mode.cha = primary_channel_enable;
  assign mode.chb = secondary_channel_enable;
  assign mode.conv = conversion_request_enable;
  assign mode.out1 = output1_request_enable;
  assign mode.out0 = output0_request_enable;

  idm_mode_dec u_dec (
    .m(mode)
  );

  // pin synchroniser: terminal count, both acknowledges, digital lines
  // acknowledges idle high; their stages reset high, the others low
  idm_sync3 #(
    .W(SYNC_W),
    .RST_VAL(SYNC_RESET)
  ) u_sync (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .d({DIGITAL_PORT_LINE_I, DMA_ACK_B_N, DMA_ACK_A_N, TRANSFER_TERMINAL_COUNT}),
    .q(pin_s)
  );

  // host pin events
  // edges from filtered levels only
  wire tc_evt = pin_s[0] & ~pin_prev[0];
  wire done_a = pin_s[1] & ~pin_prev[1]; // acknowledge released
  wire done_b = pin_s[2] & ~pin_prev[2];
  wire [DIG_W-1:0] dig_in = pin_s[SYNC_W-1:3];

  // bus decode
  // writes land at the edge where ack is high
  wire req_on = WB_CYC_I & WB_STB_I;
  wire wr_fire = req_on & WB_WE_I & ack;
  wire hit_ctrl = (WB_ADR_I == ADR_CTRL);
  wire hit_stat = (WB_ADR_I == ADR_STAT);
  wire hit_clr = (WB_ADR_I == ADR_CLR);
  wire wr_ctrl = wr_fire & hit_ctrl;
  wire clr_lane = wr_fire & hit_clr & WB_SEL_I[0];

  // control word after a byte-lane write
  // lanes two and three are dropped
  wire [7:0] next_ctrl_lo = WB_SEL_I[0] ? WB_DAT_I[7:0] : ctrl[7:0];
  wire [7:0] next_ctrl_hi = WB_SEL_I[1] ? WB_DAT_I[15:8] : ctrl[15:8];
  wire [CTRL_W-1:0] next_ctrl = wr_ctrl ? {next_ctrl_hi, next_ctrl_lo} : ctrl;

  // clear strobes
  // strobes need lane zero
  wire clr_tc = clr_lane & WB_DAT_I[C_TC];
  wire clr_out = clr_lane & WB_DAT_I[C_OUT];
  wire clr_acq = clr_lane & WB_DAT_I[C_ACQ];

  // sticky flags: a new event beats a clear in the same cycle
  // enables gate new events, never clear flags
  wire next_tc_pend = (tc_evt & transfer_count_irq_enable) | (tc_pend & ~clr_tc);
  wire next_out_pend = (OUT_SEQ_DONE & output_done_irq_enable) | (out_pend & ~clr_out);
  wire next_acq_pend = (ACQ_SEQ_DONE & acquisition_done_irq_enable) | (acq_pend & ~clr_acq);

  // converter readiness filtered by the request enables
  // raw readiness when both channels carry no request bit
  wire [1:0] outsel = {output1_request_enable, output0_request_enable};
  wire dual_free = primary_channel_enable & secondary_channel_enable &
                   ~conversion_request_enable & (outsel == 2'b00);
  wire out0_rdy = OUT0_READY & (output0_request_enable | dual_free);
  wire out1_rdy = OUT1_READY & (output1_request_enable | dual_free);
  wire conv_rdy = CONV_AVAIL & conversion_request_enable;

  // input/output interrupt sources from the mode decode
  // conversion-only dma modes time on raw converter readiness
  wire tmr_free = conversion_request_enable & (outsel == 2'b00);
  wire tmr_ready = tmr_free ? (OUT0_READY | OUT1_READY) : (out0_rdy | out1_rdy);
  wire tmr_irq_now = mode.tmr_irq & tmr_ready;
  wire conv_irq_now = mode.conv_irq & CONV_AVAIL;
  wire next_irq_any = tc_pend | out_pend | acq_pend | tmr_irq_now | conv_irq_now;

  // channel readiness and double-buffer gating
  // double-buffer: only the channel whose turn it is asks
  wire ready_a = src_ready(mode.src_a, phase_a, conv_rdy, out0_rdy, out1_rdy);
  wire ready_b = src_ready(mode.src_b, phase_b, conv_rdy, out0_rdy, out1_rdy);
  wire turn_a = ~mode.dbl | (buf_sel == BUF_A);
  wire turn_b = ~mode.dbl | (buf_sel == BUF_B);
  wire next_req_a = primary_channel_enable & mode.valid & ready_a & turn_a;
  wire next_req_b = secondary_channel_enable & mode.valid & ready_b & turn_b;

  // interleave phases advance per completed transfer
  // an acknowledge release ends one transfer
  wire next_phase_a = (mode.src_a == SRC_OUTI) ? (phase_a ^ done_a) : 1'b0;
  wire next_phase_b = (mode.src_b == SRC_OUTI) ? (phase_b ^ done_b) : 1'b0;

  // interrupt level one-hot from the line select
  wire [3:0] level = IRQ_LEVEL[irq_line_select];
  wire [NUM_LEVELS-1:0] level_hot;
  for (genvar i = 0; i < NUM_LEVELS; i++) begin : g_level
    assign level_hot[i] = (level == 4'(i));
  end

  // digital drive and sense pin enables
  wire [DIG_W-1:0] next_dig_oe = {{PORT_W{upper_port_drive_enable}},
                                  {PORT_W{lower_port_drive_enable}}};
  wire next_sense_oe = sense_ground_drive & ~NONREFERENCED_SINGLE_ENDED;

  // status word read back
  // reads have no side effects
  wire [CTRL_W-1:0] status = {dig_in, phase_b, phase_a, buf_sel, mode.valid,
                              irq_any, acq_pend, out_pend, tc_pend};
  assign rd_data = hit_stat ? {{(WB_DW - CTRL_W){1'b0}}, status} : '0;

  // double-buffer channel swap on terminal count
  // swapping at terminal count keeps blocks whole
  always_comb begin
    next_buf_sel = buf_sel;
    case (buf_sel)
      BUF_A: begin
        if (mode.dbl & tc_evt) begin
          next_buf_sel = BUF_B;
        end
      end
      BUF_B: begin
        if (mode.dbl & tc_evt) begin
          next_buf_sel = BUF_A;
        end
      end
      default: begin
        next_buf_sel = BUF_A;
      end
    endcase
    if (!mode.dbl) begin
      next_buf_sel = BUF_A;
    end
  end

  // bus answer: one ack per request, data registered with it
  // ack falls after one cycle even if the request stays
  wire take = req_on & ~ack;
  wire [WB_DW-1:0] next_dat_o = take ? rd_data : WB_DAT_O;
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ack <= 1'b0;
      WB_DAT_O <= '0;
    end else begin
      ack <= take;
      WB_DAT_O <= next_dat_o;
    end
  end
  assign WB_ACK_O = ack;

  // control word
  // write-only: never read back
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ctrl <= CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // pin history and sticky flags
  // history resets to idle levels: no false edge
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      pin_prev <= SYNC_RESET[2:0];
      tc_pend <= 1'b0;
      out_pend <= 1'b0;
      acq_pend <= 1'b0;
    end else begin
      pin_prev <= pin_s[2:0];
      tc_pend <= next_tc_pend;
      out_pend <= next_out_pend;
      acq_pend <= next_acq_pend;
    end
  end

  // channel sequencing
  // phases restart when interleave is left
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      buf_sel <= BUF_A;
      phase_a <= 1'b0;
      phase_b <= 1'b0;
    end else begin
      buf_sel <= next_buf_sel;
      phase_a <= next_phase_a;
      phase_b <= next_phase_b;
    end
  end

  // dma requests and interrupt line
  // registered: no decode glitches on host pins
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      DMA_REQ_A <= 1'b0;
      DMA_REQ_B <= 1'b0;
      irq_any <= 1'b0;
      IRQ_LEVEL_O <= '0;
    end else begin
      DMA_REQ_A <= next_req_a;
      DMA_REQ_B <= next_req_b;
      irq_any <= next_irq_any;
      IRQ_LEVEL_O <= next_irq_any ? level_hot : '0;
    end
  end

  // pin drive outputs
  // registered: link and port enables move once per write; line data tracks the latch every cycle
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      SAMPLE_LINK_ENABLE <= 1'b0;
      DIGITAL_PORT_LINE_O <= '0;
      DIGITAL_PORT_LINE_OE <= '0;
      ANALOG_SENSE_PIN_OE <= 1'b0;
    end else begin
      SAMPLE_LINK_ENABLE <= sample_link_enable;
      DIGITAL_PORT_LINE_O <= DIG_OUT_LATCH;
      DIGITAL_PORT_LINE_OE <= next_dig_oe;
      ANALOG_SENSE_PIN_OE <= next_sense_oe;
    end
  end

  // sense pin is pulled to board ground whenever driven
  assign ANALOG_SENSE_PIN_O = 1'b0;

endmodule : idm_ctrl

/* src/idm_pkg.sv */
// package for the interrupt/dma mode control register block
// assumes a 16-bit control word reached over a classic wishbone slave port
package idm_pkg;

  // bus geometry
  localparam int WB_AW = 8;
  localparam int WB_DW = 32;
  localparam int CTRL_W = 16;

  // register byte addresses
  localparam logic [7:0] ADR_CTRL = 8'h04;
  localparam logic [7:0] ADR_STAT = 8'h08;
  localparam logic [7:0] ADR_CLR = 8'h0c;

  // control register reset value
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // control register field positions
  localparam int B_LINK = 15;
  localparam int B_UP_EN = 14;
  localparam int B_LO_EN = 13;
  localparam int B_TC_IE = 12;
  localparam int B_OD_IE = 11;
  localparam int B_AD_IE = 10;
  localparam int B_IO_INT = 9;
  localparam int B_CHA = 8;
  localparam int B_CHB = 7;
  localparam int B_CONV = 6;
  localparam int B_OUT1 = 5;
  localparam int B_OUT0 = 4;
  localparam int B_SENSE = 3;
  localparam int B_LSEL_HI = 2;
  localparam int B_LSEL_LO = 0;

  // clear strobe register bit positions
  localparam int C_TC = 0;
  localparam int C_OUT = 1;
  localparam int C_ACQ = 2;

  // status register bit positions
  localparam int S_TC = 0;
  localparam int S_OUT = 1;
  localparam int S_ACQ = 2;
  localparam int S_IRQ = 3;
  localparam int S_VALID = 4;
  localparam int S_BUF = 5;
  localparam int S_PH_A = 6;
  localparam int S_PH_B = 7;
  localparam int S_DIG_LO = 8;

  // digital ports and pin synchroniser layout
  localparam int PORT_W = 4;
  localparam int DIG_W = 8;
  localparam int SYNC_W = 11;
  localparam logic [10:0] SYNC_RESET = 11'h006;

  // host interrupt levels reachable by the line select field
  localparam int NUM_LEVELS = 16;
  localparam logic [3:0] IRQ_LEVEL [8] = '{4'h3, 4'h4, 4'h5, 4'h7, 4'ha, 4'hb, 4'hc, 4'hf};

  // request source of a dma channel
  typedef enum logic [2:0] {
    SRC_NONE = 3'b000,
    SRC_OUT0 = 3'b001,
    SRC_OUT1 = 3'b010,
    SRC_OUTI = 3'b011,
    SRC_CONV = 3'b100
  } idm_src_e;

  // active channel of a double-buffered pair
  typedef enum logic {
    BUF_A = 1'b0,
    BUF_B = 1'b1
  } idm_buf_e;

endpackage : idm_pkg

/* src/idm_mode_if.sv */
// mode bits in, channel routing and interrupt kinds out
// assumes idm_pkg is compiled first
`timescale 1ns/1ps
interface idm_mode_if import idm_pkg::*; ();
  logic io_int;
  logic cha;
  logic chb;
  logic conv;
  logic out1;
  logic out0;
  idm_src_e src_a;
  idm_src_e src_b;
  logic dbl;
  logic tmr_irq;
  logic conv_irq;
  logic valid;
  modport dec (input io_int, cha, chb, conv, out1, out0,
               output src_a, src_b, dbl, tmr_irq, conv_irq, valid);
  modport ctl (output io_int, cha, chb, conv, out1, out0,
               input src_a, src_b, dbl, tmr_irq, conv_irq, valid);
endinterface : idm_mode_if

/* src/idm_sync3.sv */
// three-flop pin synchroniser; output follows once stages two and three agree
// assumes asynchronous pins and one system clock
`timescale 1ns/1ps
module idm_sync3 import idm_pkg::*; #(
  parameter int W = SYNC_W,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins and filtered levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  wire [W-1:0] agree = ~(s2 ^ s3);
  wire [W-1:0] next_q = (s3 & agree) | (q & ~agree);

  // shift chain; the first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
      q <= RST_VAL;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
    end
  end
endmodule : idm_sync3

/* src/idm_mode_dec.sv */
// decode of the interrupt/dma mode bits into channel sources
// assumes only listed combinations are written; others route nothing
`timescale 1ns/1ps
module idm_mode_dec import idm_pkg::*; (
  // mode bits in, routing out
  idm_mode_if.dec m
);
  // converter selection shared by the single, dual and mixed converter routings
  function automatic idm_src_e out_source(input logic [1:0] s);
    case (s)
      2'b01: out_source = SRC_OUT0;
      2'b10: out_source = SRC_OUT1;
      2'b11: out_source = SRC_OUTI;
      default: out_source = SRC_NONE;
    endcase
  endfunction : out_source

  // channel and request class terms
  wire [1:0] outsel = {m.out1, m.out0};
  wire any_out = |outsel;
  wire single_a = m.cha & ~m.chb;
  wire single_b = ~m.cha & m.chb;
  wire both = m.cha & m.chb;
  wire neither = ~m.cha & ~m.chb;
  wire conv_only = m.conv & ~any_out;
  wire out_only = ~m.conv & any_out;
  wire single_ok = (single_a | single_b) & (conv_only | out_only);
  wire both_out = both & ~m.conv;
  wire both_conv = both & conv_only;
  wire both_mix = both & m.conv & any_out;
  wire sync_dual = both_out & (outsel == 2'b11);
  wire irq_only = neither & m.io_int & (m.conv | any_out);
  idm_src_e out_src;
  idm_src_e single_src;
  idm_src_e dual_out;
  assign out_src = out_source(outsel);
  assign single_src = conv_only ? SRC_CONV : out_src;
  assign dual_out = any_out ? out_src : SRC_OUTI;

  // channel routing
  assign m.src_a = (single_a & single_ok) ? single_src :
                   sync_dual ? SRC_OUT0 :
                   both_out ? dual_out :
                   both_conv ? SRC_CONV :
                   both_mix ? (m.io_int ? out_src : SRC_CONV) : SRC_NONE;
  assign m.src_b = (single_b & single_ok) ? single_src :
                   sync_dual ? SRC_OUT1 :
                   both_out ? dual_out :
                   both_conv ? SRC_CONV :
                   both_mix ? (m.io_int ? SRC_CONV : out_src) : SRC_NONE;
  assign m.dbl = (both_out & ~sync_dual) | both_conv;

  // interrupt kinds
  assign m.tmr_irq = m.io_int & ((neither & any_out) | ((single_a | single_b) & conv_only) | both_conv);
  assign m.conv_irq = m.io_int & ((neither & m.conv) | ((single_a | single_b) & out_only) | both_out);
  assign m.valid = single_ok | both_out | both_conv | both_mix | irq_only;
endmodule : idm_mode_dec

/* sim/idm_ctrl_props.sv */
// concurrent checks on the mode control register block
// assumes it is bound to idm_ctrl and sees only that module's ports
`timescale 1ns/1ps
module idm_ctrl_props import idm_pkg::*; (
  // clock, reset and bus
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [WB_AW-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [WB_DW-1:0] WB_DAT_I,
  input wire logic [WB_DW-1:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  // outputs under watch and the non-referenced mode input
  input wire logic [NUM_LEVELS-1:0] IRQ_LEVEL_O,
  input wire logic SAMPLE_LINK_ENABLE,
  input wire logic [DIG_W-1:0] DIGITAL_PORT_LINE_OE,
  input wire logic NONREFERENCED_SINGLE_ENDED,
  input wire logic ANALOG_SENSE_PIN_OE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // accepted write reaching the upper control lane
  sequence s_ctrl_wr;
    WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O && WB_ADR_I == ADR_CTRL && WB_SEL_I[1];
  endsequence
  // accepted read of the write-only control word
  sequence s_ctrl_rd;
    WB_CYC_I && WB_STB_I && !WB_WE_I && WB_ACK_O && WB_ADR_I == ADR_CTRL;
  endsequence
  AST_ACK_NEXT: assert property ($rose(WB_STB_I) |=> WB_ACK_O) else $error("ack not one cycle after request");
  AST_ACK_ONE: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
  AST_CTRL_RD: assert property (s_ctrl_rd |-> WB_DAT_O == '0) else $error("control word readable");
  AST_LINK: assert property (s_ctrl_wr |-> ##2 SAMPLE_LINK_ENABLE == $past(WB_DAT_I[B_LINK], 2))
    else $error("link enable does not follow bit 15");
  AST_UP_OE: assert property (s_ctrl_wr |-> ##2 DIGITAL_PORT_LINE_OE[7:4] == {4{$past(WB_DAT_I[B_UP_EN], 2)}})
    else $error("upper port enable does not follow bit 14");
  AST_LO_OE: assert property (s_ctrl_wr |-> ##2 DIGITAL_PORT_LINE_OE[3:0] == {4{$past(WB_DAT_I[B_LO_EN], 2)}})
    else $error("lower port enable does not follow bit 13");
  AST_SENSE_NONREFERENCED_SINGLE_ENDED: assert property (ANALOG_SENSE_PIN_OE |-> !$past(NONREFERENCED_SINGLE_ENDED))
    else $error("sense pin driven in non-referenced mode");
  AST_IRQ_LEVEL: assert property ($onehot0(IRQ_LEVEL_O) && (IRQ_LEVEL_O & ~16'h9cb8) == '0)
    else $error("interrupt on an unselectable or second level");
endmodule : idm_ctrl_props

bind idm_ctrl idm_ctrl_props i_idm_ctrl_props (.CLK_SYS, .RST_N, .WB_CYC_I, .WB_STB_I, .WB_WE_I,
  .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .IRQ_LEVEL_O, .SAMPLE_LINK_ENABLE,
  .DIGITAL_PORT_LINE_OE, .NONREFERENCED_SINGLE_ENDED, .ANALOG_SENSE_PIN_OE);

/* sim/idm_host_model.sv */
// stand-in for the host dma and interrupt controller
// assumes requests are registered levels on the system clock
`timescale 1ns/1ps
module idm_host_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // requests from the block and a terminal count command
  input wire logic req_a,
  input wire logic req_b,
  input wire logic tc_go,
  // pins back to the block
  output logic tc,
  output logic ack_a_n,
  output logic ack_b_n
);
  logic [1:0] tc_cnt;
  logic [2:0] gap;
  // terminal count held three cycles so the pin synchroniser sees it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tc_cnt <= 2'h0;
    end else if (tc_go) begin
      tc_cnt <= 2'h3;
    end else if (tc_cnt != 2'h0) begin
      tc_cnt <= tc_cnt - 2'h1;
    end
  end
  assign tc = (tc_cnt != 2'h0);
  // slow grants: one low cycle per channel every eight cycles while asked
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap <= 3'h0;
      ack_a_n <= 1'b1;
      ack_b_n <= 1'b1;
    end else begin
      gap <= gap + 3'h1;
      ack_a_n <= !(req_a && gap == 3'h7);
      ack_b_n <= !(req_b && gap == 3'h3);
    end
  end
endmodule : idm_host_model

/* sim/idm_ctrl_tb.sv */
// self-checking bench for the mode control register block
// assumes package, design, checker and host model are compiled first
`timescale 1ns/1ps
module idm_ctrl_tb import idm_pkg::*;;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, tc_go = 1'b0;
  logic conv = 1'b0, o0 = 1'b0, o1 = 1'b0, osd = 1'b0, asd = 1'b0, nonreferenced_single_ended = 1'b0;
  logic [7:0] adr = 8'h00, latch = 8'h3c, pins, dig_o, dig_oe;
  logic [31:0] dat = 32'h0, rdat, dat_o;
  logic tc, ack_a_n, ack_b_n, req_a, req_b, link, sense_o, sense_oe, ack;
  logic [15:0] irq;
  int fails = 0, tests_run = 0;
  int lvl [8] = '{3, 4, 5, 7, 10, 11, 12, 15};
  // mode words, events {conv,out1,out0} and expected {req_a,req_b,irq}
  logic [15:0] mc [17] = '{16'h0110, 16'h0120, 16'h0130, 16'h0140, 16'h00a0, 16'h00c0,
    16'h01d0, 16'h0120, 16'h0010, 16'h0210, 16'h0250, 16'h0240, 16'h0180, 16'h0190, 16'h01b0,
    16'h0340, 16'h0310};
  logic [2:0] ev [17] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h2, 3'h4, 3'h5, 3'h1, 3'h1, 3'h1, 3'h4, 3'h4,
    3'h3, 3'h3, 3'h3, 3'h5, 3'h5};
  logic [2:0] ex [17] = '{3'h4, 3'h4, 3'h4, 3'h4, 3'h2, 3'h2, 3'h6, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1,
    3'h4, 3'h4, 3'h6, 3'h5, 3'h5};
  always #10 clk = ~clk;
  // undriven lines show the outside pattern 5a
  assign pins = (dig_oe & dig_o) | (~dig_oe & 8'h5a);
  idm_ctrl i_idm_ctrl (.CLK_SYS(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .TRANSFER_TERMINAL_COUNT(tc), .DMA_ACK_A_N(ack_a_n), .DMA_ACK_B_N(ack_b_n), .DMA_REQ_A(req_a),
    .DMA_REQ_B(req_b), .IRQ_LEVEL_O(irq), .CONV_AVAIL(conv), .OUT0_READY(o0), .OUT1_READY(o1),
    .OUT_SEQ_DONE(osd), .ACQ_SEQ_DONE(asd), .SAMPLE_LINK_ENABLE(link), .DIG_OUT_LATCH(latch),
    .DIGITAL_PORT_LINE_I(pins), .DIGITAL_PORT_LINE_O(dig_o), .DIGITAL_PORT_LINE_OE(dig_oe),
    .NONREFERENCED_SINGLE_ENDED(nonreferenced_single_ended), .ANALOG_SENSE_PIN_O(sense_o), .ANALOG_SENSE_PIN_OE(sense_oe));
  idm_host_model i_idm_host_model (.clk(clk), .rst_n(rst_n), .req_a(req_a), .req_b(req_b),
    .tc_go(tc_go), .tc(tc), .ack_a_n(ack_a_n), .ack_b_n(ack_b_n));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one classic bus cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude
  // link, port drive, sense pin, readback and unmapped access
  task automatic s_fields();
    chk("reset outputs", 0, {link, dig_oe, req_a, req_b, irq, sense_oe});
    wb(1'b1, ADR_CTRL, 32'he008);
    tick(6);
    chk("link on", 1, link);
    chk("port oe", 32'hff, dig_oe);
    chk("sense oe", 1, sense_oe);
    chk("sense level", 0, sense_o);
    wb(1'b0, ADR_STAT, 0);
    chk("driven lines", 32'h3c, rdat[15:8]);
    wb(1'b0, ADR_CTRL, 0);
    chk("ctrl read", 0, rdat);
    nonreferenced_single_ended <= 1'b1;
    wb(1'b1, ADR_CTRL, 32'h2008);
    tick(6);
    chk("link off", 0, link);
    chk("sense nonreferenced_single_ended", 0, sense_oe);
    wb(1'b0, ADR_STAT, 0);
    chk("upper released", 32'h5c, rdat[15:8]);
    wb(1'b1, ADR_CTRL, 32'h4000);
    tick(6);
    wb(1'b0, ADR_STAT, 0);
    chk("lower released", 32'h3a, rdat[15:8]);
    nonreferenced_single_ended <= 1'b0;
    wb(1'b1, 8'h20, 32'hffff);
    wb(1'b0, 8'h20, 0);
    chk("unmapped read", 0, rdat);
    chk("unmapped write", 32'hf0, dig_oe);
  endtask : s_fields
  // terminal count interrupt on every selectable level, then cleared
  task automatic s_tc();
    for (int k = 0; k < 8; k++) begin
      wb(1'b1, ADR_CTRL, 32'h1000 | k);
      tc_go <= 1'b1;
      @(posedge clk);
      tc_go <= 1'b0;
      tick(10);
      chk("tc irq level", 32'h1 << lvl[k], irq);
      wb(1'b1, ADR_CLR, 32'h1);
      tick(3);
      chk("tc cleared", 0, irq);
    end
  endtask : s_tc
  // sequence-done interrupts enabled and disabled
  task automatic s_done();
    logic [15:0] en [3] = '{16'h0800, 16'h0400, 16'h0000};
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, ADR_CTRL, {16'h0, en[k]});
      if (k == 1) asd <= 1'b1;
      else osd <= 1'b1;
      @(posedge clk);
      osd <= 1'b0;
      asd <= 1'b0;
      tick(4);
      chk("done irq", (en[k] != 0) ? 32'h8 : 32'h0, irq);
      wb(1'b1, ADR_CLR, 32'h7);
      tick(3);
      chk("done cleared", 0, irq);
    end
  endtask : s_done
  // mode table: routing, refused channels and interrupt kinds
  task automatic s_modes();
    for (int k = 0; k < 17; k++) begin
      wb(1'b1, ADR_CTRL, {16'h0, mc[k]});
      {conv, o1, o0} <= ev[k];
      tick(6);
      chk("mode routing", ex[k], {req_a, req_b, |irq});
      {conv, o1, o0} <= 3'b000;
      tick(2);
    end
    wb(1'b1, ADR_CTRL, 32'h01c0);
    conv <= 1'b1;
    tick(4);
    chk("dbl first", 32'h2, {req_a, req_b});
    tc_go <= 1'b1;
    @(posedge clk);
    tc_go <= 1'b0;
    tick(10);
    chk("dbl swap", 32'h1, {req_a, req_b});
    conv <= 1'b0;
  endtask : s_modes
  // watchdog far beyond the few hundred cycles the run needs
  initial begin
    #50000;
    fails++;
    conclude();
  end
  initial begin
    tick(2);
    rst_n <= 1'b1;
    tick(2);
    s_fields();
    s_tc();
    s_done();
    s_modes();
    conclude();
  end
endmodule : idm_ctrl_tb
